// file: hdl/throttle_pkg.sv
// Package for the thermal clock throttle: offsets, fields, timing, types.
// Assumes a 200 MHz system clock and an 8-bit die temperature code, 1 C/LSB.
package throttle_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  // Longest single clock-off or clock-on stretch while throttling
  localparam int MAX_PHASE_NS  = 3000;
  localparam int MAX_PHASE_CYC = MAX_PHASE_NS / CLK_PERIOD_NS;
  // Eighths per modulation period; 7 eighths is the longest on stretch
  localparam int NUM_STEPS     = 8;
  localparam int MAX_ON_STEPS  = 7;
  localparam int STEP_CYCLES   = MAX_PHASE_CYC / MAX_ON_STEPS;
  // Hysteresis hold time before automatic throttling may end
  localparam int HYST_NS       = 2000;
  localparam int HYST_CYC      = (HYST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Hidden temperature thresholds (degrees C codes)
  // ----------------------------------------------------------------
  localparam logic [7:0] HOT_TRIP_C     = 8'h7D;
  localparam logic [7:0] HOT_RELEASE_C  = 8'h7A;
  localparam logic [7:0] CAT_TRIP_C     = 8'h87;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] EVENT_OFS  = 8'h08;

  localparam int CTRL_AUTO_BIT  = 0;
  localparam int CTRL_DUTY_LSB  = 1;
  localparam int CTRL_OD_BIT    = 4;
  localparam int CTRL_EVA_BIT   = 5;
  localparam int CTRL_EVD_BIT   = 6;
  localparam int CTRL_WIDTH     = 7;
  localparam int STATUS_WIDTH   = 4;
  localparam int EVENT_WIDTH    = 2;

  localparam logic [6:0] CTRL_RESET  = 7'h00;
  localparam logic [2:0] AUTO_DUTY   = 3'h4;
  localparam logic [2:0] DUTY_OFF    = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ev_deassert_en;
    logic       ev_assert_en;
    logic       od_en;
    logic [2:0] duty;
    logic       auto_en;
  } ctrl_s;

  typedef struct packed {
    logic trip;
    logic core_clk_on;
    logic auto_hot;
    logic throttling;
  } status_s;

  typedef struct packed {
    logic deasserted;
    logic asserted;
  } event_s;

  typedef enum logic [1:0] {
    AUTO_IDLE = 2'b00,
    AUTO_HOT  = 2'b01,
    AUTO_HYST = 2'b11
  } auto_state_e;

endpackage : throttle_pkg

// file: hdl/step_divider.sv
// Step divider: a one-cycle tick every STEP_CYCLES clocks while running.
// Assumes the caller restarts it with run low whenever throttling starts.
module step_divider
  import throttle_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  // Enable pulse
  output logic      tick
);

  localparam logic [9:0] LAST = 10'(STEP_CYCLES - 1);

  logic [9:0] count;
  wire        at_last = (count == LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 10'h000;
    end else if (!run || at_last) begin
      count <= 10'h000;
    end else begin
      count <= count + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && at_last;
    end
  end

endmodule : step_divider

// file: hdl/thermal_clock_throttle.sv
// Thermal clock throttle: gates core clocks under heat or software demand,
// drives the hot and catastrophic trip pins, APB register slave.
// Assumes DIE_TEMP is synchronous to CLK_SYS and the clock tree obeys
// CORE_CLK_EN and UNCORE_CLK_EN within one cycle.
//
// The APB interface to the registers and the address map were chosen for this implementation.
module thermal_clock_throttle
  import throttle_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Temperature sensor
  input  wire logic [7:0]  DIE_TEMP,
  // Clock tree controls
  output logic             CORE_CLK_EN,
  output logic             UNCORE_CLK_EN,
  // Platform pins and event
  output logic             THERMAL_HOT_OUT_N,
  output logic             CATASTROPHIC_TRIP_OUT_N,
  output logic             THROTTLE_EVENT
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_phase = PSEL && !PENABLE;
  wire access      = PSEL && PENABLE && PREADY;
  wire wr_access   = access && PWRITE;
  wire hit_ctrl    = (PADDR == CTRL_OFS);
  wire hit_status  = (PADDR == STATUS_OFS);
  wire hit_event   = (PADDR == EVENT_OFS);
  wire mapped      = hit_ctrl || hit_status || hit_event;
  wire wr_ctrl     = wr_access && hit_ctrl && PSTRB[0];
  wire wr_event    = wr_access && hit_event && PSTRB[0];

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  ctrl_s        ctrl;
  event_s       events;
  auto_state_e  auto_state;
  auto_state_e  next_auto_state;
  logic [8:0]   hyst_count;
  logic [2:0]   phase;
  logic         throttling;
  logic         trip;

  // ----------------------------------------------------------------
  // Temperature compares
  // ----------------------------------------------------------------
  // Thresholds are constants only; no register reads or writes them
  // fixed hidden thresholds
  wire temp_hot   = (DIE_TEMP >= HOT_TRIP_C);
  wire temp_cool  = (DIE_TEMP <= HOT_RELEASE_C);
  wire temp_cat   = (DIE_TEMP >= CAT_TRIP_C);
  wire hyst_done  = (hyst_count == 9'h000);

  // ----------------------------------------------------------------
  // Automatic mode state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_auto_state = auto_state;
    unique case (auto_state)
      AUTO_IDLE: begin
        if (ctrl.auto_en && temp_hot) begin
          next_auto_state = AUTO_HOT;
        end
      end
      AUTO_HOT: begin
        if (!ctrl.auto_en) begin
          next_auto_state = AUTO_IDLE;
        end else if (temp_cool) begin
          next_auto_state = AUTO_HYST;
        end
      end
      AUTO_HYST: begin
        if (!ctrl.auto_en) begin
          next_auto_state = AUTO_IDLE;
        end else if (!temp_cool) begin
          next_auto_state = AUTO_HOT;
        end else if (hyst_done) begin
          next_auto_state = AUTO_IDLE;
        end
      end
      default: begin
        next_auto_state = AUTO_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      auto_state <= AUTO_IDLE;
    end else begin
      auto_state <= next_auto_state;
    end
  end

  // Timer reloads on every hot sample, so brief dips do not end throttling
  // hysteresis timer
  wire hyst_load = (auto_state != AUTO_HYST) || !temp_cool;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      hyst_count <= 9'h000;
    end else if (hyst_load) begin
      hyst_count <= 9'(HYST_CYC - 1);
    end else if (!hyst_done) begin
      hyst_count <= hyst_count - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Throttle activation and duty selection
  // ----------------------------------------------------------------
  wire auto_hot   = (auto_state != AUTO_IDLE);
  wire od_active  = ctrl.od_en && (ctrl.duty != DUTY_OFF);
  // A latched trip beats both modes: the clocks stop outright instead,
  // so the hot pin must not claim modulation that is not happening.
  // on-demand regardless of temperature
  wire next_throttling = !trip && (auto_hot || od_active);

  wire [2:0] on_steps = auto_hot ? AUTO_DUTY : ctrl.duty;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      throttling <= 1'b0;
    end else begin
      throttling <= next_throttling;
    end
  end

  // ----------------------------------------------------------------
  // Modulation step timing
  // ----------------------------------------------------------------
  // Steps are counted in CLK_SYS cycles, so the period does not follow the
  // core clock rate; the step is sized so seven steps stay under the limit.
  // period in CLK_SYS cycles
  logic step_tick;

  step_divider u_step (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .run   (throttling),
    .tick  (step_tick)
  );

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      phase <= 3'h0;
    end else if (!throttling) begin
      phase <= 3'h0;
    end else if (step_tick) begin
      phase <= phase + 3'h1;
    end
  end

  // Phase below the on count means clocks run in this eighth
  // alternate clocks off and on
  wire core_on_slot = !throttling || (phase < on_steps);
  wire next_core_en = !trip && !temp_cat && core_on_slot;

  // Snoop and interrupt logic sit on the uncore clock, which only a
  // catastrophic trip stops.
  // uncore never throttled
  wire next_uncore_en = !trip && !temp_cat;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CORE_CLK_EN <= 1'b0;
    end else begin
      CORE_CLK_EN <= next_core_en;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      UNCORE_CLK_EN <= 1'b0;
    end else begin
      UNCORE_CLK_EN <= next_uncore_en;
    end
  end

  // ----------------------------------------------------------------
  // Catastrophic trip
  // ----------------------------------------------------------------
  // Driven only from the sensor; no bus access, no core activity.
  // sensor-only path
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      trip <= 1'b0;
    end else if (temp_cat) begin
      trip <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      CATASTROPHIC_TRIP_OUT_N <= 1'b1;
    end else begin
      CATASTROPHIC_TRIP_OUT_N <= !(trip || temp_cat);
    end
  end

  // ----------------------------------------------------------------
  // Hot pin and throttle events
  // ----------------------------------------------------------------
  wire rise = next_throttling && !throttling;
  wire fall = !next_throttling && throttling;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      THERMAL_HOT_OUT_N <= 1'b1;
    end else begin
      THERMAL_HOT_OUT_N <= !next_throttling;
    end
  end

  wire next_event = (rise && ctrl.ev_assert_en) ||
                    (fall && ctrl.ev_deassert_en);

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      THROTTLE_EVENT <= 1'b0;
    end else begin
      THROTTLE_EVENT <= next_event;
    end
  end

  // Sticky log of entries and exits; write one clears, a new edge in
  // the same cycle wins over the clear.
  wire [1:0] ev_set   = {fall, rise};
  wire [1:0] ev_clear = wr_event ? PWDATA[EVENT_WIDTH-1:0] : 2'b00;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      events <= '0;
    end else begin
      events <= event_s'((events & ~ev_clear) | ev_set);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Takes effect at the access edge; on-demand throttling follows one cycle later, automatic throttling two cycles later
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl <= ctrl_s'(CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl <= ctrl_s'(PWDATA[CTRL_WIDTH-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  status_s status;
  assign status = '{trip:        trip,
                    core_clk_on: CORE_CLK_EN,
                    auto_hot:    auto_hot,
                    throttling:  throttling};

  wire [31:0] rd_ctrl   = {25'h000_0000, ctrl};
  wire [31:0] rd_status = {28'h000_0000, status};
  wire [31:0] rd_event  = {30'h0000_0000, events};
  wire [31:0] rd_data   = hit_ctrl   ? rd_ctrl   :
                          hit_status ? rd_status :
                          hit_event  ? rd_event  : 32'h0000_0000;

  // One access cycle: ready is raised by the setup cycle, so no wait
  // states are ever inserted and the master never stalls.
  wire        next_ready  = setup_phase;
  wire        next_slverr = setup_phase && !mapped;
  // Read data only in the access cycle of a read; zero otherwise so a
  // stale word never shows on the bus.
  wire [31:0] next_prdata = (setup_phase && !PWRITE) ? rd_data :
                                                       32'h0000_0000;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= next_ready;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= next_slverr;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= next_prdata;
    end
  end

endmodule : thermal_clock_throttle

// file: dv/throttle_properties.sv
// Checker for the thermal clock throttle, bound to its top-level ports.
// Assumes one clock domain, CLK_SYS, with asynchronous RESETN.
module throttle_properties
  import throttle_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  // APB slave
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Sensor, clock tree, pins
  input wire logic [7:0]  DIE_TEMP,
  input wire logic        CORE_CLK_EN,
  input wire logic        UNCORE_CLK_EN,
  input wire logic        THERMAL_HOT_OUT_N,
  input wire logic        CATASTROPHIC_TRIP_OUT_N,
  input wire logic        THROTTLE_EVENT
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [11:0] on_len;
  logic [11:0] off_len;
  logic        was_up;
  wire         thr     = !THERMAL_HOT_OUT_N;
  wire         ctrl_wr = PSEL && PENABLE && PREADY && PWRITE &&
                         PADDR == CTRL_OFS && PSTRB[0];
  wire         od_on   = PWDATA[CTRL_OD_BIT] &&
                         PWDATA[CTRL_DUTY_LSB +: 3] != DUTY_OFF;
  wire         all_off = !PWDATA[CTRL_AUTO_BIT] &&
                         PWDATA[CTRL_DUTY_LSB +: 3] == DUTY_OFF;

  // Stretch lengths only while throttling; trip periods are not bounded
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      on_len  <= 12'h000;
      off_len <= 12'h000;
      was_up  <= 1'b0;
    end else begin
      on_len  <= (thr && CORE_CLK_EN) ? on_len + 12'h001 : 12'h000;
      off_len <= (thr && !CORE_CLK_EN) ? off_len + 12'h001 : 12'h000;
      was_up  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_trip_entry: assert property (
    DIE_TEMP >= CAT_TRIP_C |-> ##[1:2] !CATASTROPHIC_TRIP_OUT_N)
    else $error("trip pin not asserted on overheat");
  a_trip_hold: assert property (
    !CATASTROPHIC_TRIP_OUT_N |=> !CATASTROPHIC_TRIP_OUT_N)
    else $error("trip pin released before reset");
  a_trip_stop: assert property (
    !CATASTROPHIC_TRIP_OUT_N |-> !CORE_CLK_EN && !UNCORE_CLK_EN)
    else $error("clocks running during trip");
  a_uncore_run: assert property (
    was_up && CATASTROPHIC_TRIP_OUT_N |-> UNCORE_CLK_EN)
    else $error("snoop clock stopped without trip");
  a_off_bound: assert property (
    off_len <= MAX_PHASE_CYC)
    else $error("clock off stretch too long");
  a_on_bound: assert property (
    on_len <= MAX_PHASE_CYC)
    else $error("clock on stretch too long");
  a_od_start: assert property (
    ctrl_wr && od_on && CATASTROPHIC_TRIP_OUT_N && DIE_TEMP < CAT_TRIP_C
    |-> ##[1:2] thr)
    else $error("on-demand write did not start throttling");
  a_od_stop: assert property (
    ctrl_wr && all_off |-> ##[1:2] THERMAL_HOT_OUT_N)
    else $error("hot pin stays low with modes off");
  a_ready_wait: assert property (
    PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
  a_err_data: assert property (
    PSLVERR |-> PREADY && PRDATA == 32'h0000_0000)
    else $error("error response carries data");

  c_od_write: cover property (ctrl_wr && od_on);
  c_hot_fall: cover property ($fell(THERMAL_HOT_OUT_N));
  c_trip_fall: cover property ($fell(CATASTROPHIC_TRIP_OUT_N));
endmodule : throttle_properties

bind thermal_clock_throttle throttle_properties chk (
  .CLK_SYS, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .PREADY, .PSLVERR, .DIE_TEMP, .CORE_CLK_EN, .UNCORE_CLK_EN,
  .THERMAL_HOT_OUT_N, .CATASTROPHIC_TRIP_OUT_N, .THROTTLE_EVENT
);

// file: dv/clock_tree_model.sv
// Clock tree model: records core clock gating stretches while throttling.
// Assumes core_en and hot_n are the registered outputs of the throttle.
module clock_tree_model (
  // Clock
  input  wire logic clk,
  // Gating controls
  input  wire logic core_en,
  input  wire logic hot_n,
  // Last completed stretches, in cycles
  output int        last_on,
  output int        last_off
);
  timeunit 1ns;
  timeprecision 100ps;

  int   run  = 0;
  logic prev = 1'b0;

  always @(posedge clk) begin
    if (core_en !== prev && hot_n === 1'b0) begin
      if (prev === 1'b1) last_on <= run;
      else last_off <= run;
    end
    run  <= (core_en !== prev) ? 1 : run + 1;
    prev <= core_en;
  end
endmodule : clock_tree_model

// file: dv/tb_top.sv
// Testbench for the thermal clock throttle: APB tasks, directed tests.
// Assumes the clock tree model measures gating stretches.
module tb_top
  import throttle_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'h1;
  logic [7:0]  temp    = 8'h20;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, perr, core_en, uncore_en, hot_n, trip_n, ev;
  int          miscompares = 0;
  int          check_count = 0;
  int          ev_cnt = 0;
  int          e0, last_on, last_off;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (ev === 1'b1) ev_cnt++;

  thermal_clock_throttle uut (
    .CLK_SYS(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .DIE_TEMP(temp),
    .CORE_CLK_EN(core_en), .UNCORE_CLK_EN(uncore_en),
    .THERMAL_HOT_OUT_N(hot_n), .CATASTROPHIC_TRIP_OUT_N(trip_n),
    .THROTTLE_EVENT(ev));
  clock_tree_model tree (.clk(clk), .core_en(core_en), .hot_n(hot_n),
    .last_on(last_on), .last_off(last_off));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    chk("pready", 1, pready);
    if (n == 16) final_report();
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_hot(input logic v, input int lim);
    int n;
    n = 0;
    while (hot_n !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("hot_n", v, hot_n);
    if (n == lim) final_report();
  endtask : wait_hot

  // Two full periods guarantee one whole on and off stretch after a change
  task automatic duty(input int on_c);
    repeat (2 * NUM_STEPS * STEP_CYCLES) @(posedge clk);
    chk("on stretch", on_c, last_on);
    chk("off stretch", NUM_STEPS * STEP_CYCLES - on_c, last_off);
  endtask : duty

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, CTRL_OFS, 0);
    chk("ctrl reset", 0, rd);
    apb(0, STATUS_OFS, 0);
    chk("status reset", 32'h0000_0004, rd);
    apb(0, 8'h0C, 0);
    chk("unmapped err", 1, perr);
    chk("unmapped data", 0, rd);
    pstrb <= 4'h0;
    apb(1, CTRL_OFS, 32'h0000_0013);
    pstrb <= 4'h1;
    apb(0, CTRL_OFS, 0);
    chk("ctrl strobe", 0, rd);
    e0 = ev_cnt;
    for (int n = 1; n <= MAX_ON_STEPS; n++) begin
      apb(1, CTRL_OFS, 32'h0000_0070 | 32'(n << 1));
      wait_hot(1'b0, 4);
      duty(n * STEP_CYCLES);
    end
    apb(0, STATUS_OFS, 0);
    chk("status thr", 1, rd[0]);
    apb(1, CTRL_OFS, 32'h0000_0070);
    wait_hot(1'b1, 4);
    // Let the exit pulse be counted before the count is read
    @(posedge clk);
    chk("event pulses", 2, ev_cnt - e0);
    apb(0, EVENT_OFS, 0);
    chk("event flags", 32'h0000_0003, rd);
    apb(1, EVENT_OFS, 32'h0000_0003);
    apb(0, EVENT_OFS, 0);
    chk("event clear", 0, rd);
    apb(1, CTRL_OFS, 32'h0000_0001);
    temp <= HOT_TRIP_C - 8'h01;
    repeat (20) @(posedge clk);
    chk("hot_n cool", 1, hot_n);
    temp <= HOT_TRIP_C;
    wait_hot(1'b0, 4);
    duty(4 * STEP_CYCLES);
    chk("uncore thr", 1, uncore_en);
    apb(1, CTRL_OFS, 32'h0000_0013);
    duty(4 * STEP_CYCLES);
    apb(1, CTRL_OFS, 32'h0000_0001);
    temp <= HOT_RELEASE_C;
    repeat (200) @(posedge clk);
    temp <= HOT_RELEASE_C + 8'h01;
    @(posedge clk);
    temp <= HOT_RELEASE_C;
    repeat (HYST_CYC - 20) @(posedge clk);
    chk("hot_n hyst", 0, hot_n);
    wait_hot(1'b1, 40);
    temp <= CAT_TRIP_C;
    repeat (3) @(posedge clk);
    chk("trip_n", 0, trip_n);
    chk("core trip", 0, core_en);
    chk("uncore trip", 0, uncore_en);
    temp <= 8'h20;
    repeat (20) @(posedge clk);
    chk("trip held", 0, trip_n);
    apb(0, STATUS_OFS, 0);
    chk("status trip", 1, rd[3]);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("trip reset", 1, trip_n);
    chk("core reset", 1, core_en);
    final_report();
  end
endmodule : tb_top
